/* File: core/mpu_region_config_regs.sv */
// region programming registers of the memory protection unit
`timescale 1ns/1ps
`include "mpu_region_consts.svh"
module mpu_region_config_regs #(
  parameter int REGIONS = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // register port
  input wire mpu_region_pkg::reg_req_t req,
  input wire logic [1:0] hw_sel,
  output logic [31:0] rdata,
  // lookup of the current region
  output mpu_region_pkg::region_view_t cur_view,
  output logic [2:0] cur_region,
  output logic [REGIONS-1:0] region_on
);
  import mpu_region_pkg::*;

  typedef struct packed {
    logic [2:0] rnr;
    logic [REGIONS-1:0][26:0] base;
    region_attr_t [REGIONS-1:0] attr;
    logic [31:0] rdata;
    region_view_t view;
    logic [REGIONS-1:0] on;
    wr_kind_t last_wr;
  } state_t;

  state_t st_r;
  state_t st_nxt;
  region_view_t dec_view;

  function automatic logic [31:0] pack_attr(input region_attr_t a);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[`ATTR_XN_BIT] = a.xn;
    w[`ATTR_AP_LSB +: 3] = a.ap;
    w[`ATTR_TEX_LSB +: 3] = a.type_extension;
    w[`ATTR_S_BIT] = a.s;
    w[`ATTR_C_BIT] = a.c;
    w[`ATTR_B_BIT] = a.b;
    w[`ATTR_SRD_LSB +: 8] = a.subregion_disable_mask;
    w[`ATTR_SIZE_LSB +: 5] = a.size;
    w[`ATTR_ENABLE_BIT] = a.enable;
    return w;
  endfunction : pack_attr

  function automatic region_attr_t unpack_attr(input logic [31:0] w);
    region_attr_t a;
    a.xn = w[`ATTR_XN_BIT];
    a.ap = w[`ATTR_AP_LSB +: 3];
    a.type_extension = w[`ATTR_TEX_LSB +: 3];
    a.s = w[`ATTR_S_BIT];
    a.c = w[`ATTR_C_BIT];
    a.b = w[`ATTR_B_BIT];
    a.subregion_disable_mask = w[`ATTR_SRD_LSB +: 8];
    a.size = w[`ATTR_SIZE_LSB +: 5];
    a.enable = w[`ATTR_ENABLE_BIT];
    return a;
  endfunction : unpack_attr

  function automatic logic is_base(input logic [7:0] a);
    // alias decodes as the base register
    return (a == `OFS_REGION_BASE) || (a == `OFS_REGION_BASE_A1);
  endfunction : is_base

  function automatic logic is_attr(input logic [7:0] a);
    return (a == `OFS_REGION_ATTR) || (a == `OFS_REGION_ATTR_A1);
  endfunction : is_attr

  function automatic logic [31:0] read_base(input logic [26:0] b,
                                            input logic [2:0] n,
                                            input logic [4:0] size);
    logic [31:0] w;
    logic [31:0] m;
    // only bits 31 to N are kept
    m = 32'hFFFF_FFFF >> (5'h1F - size);
    w = {b, 5'h00} & ~m;
    // no address field at full size
    if (size == `SIZE_FULL) begin
      w = 32'h0000_0000;
    end
    // region field in bits 3 to 0
    w[`BASE_REGION_LSB +: 4] = {1'b0, n};
    w[`BASE_VALID_BIT] = 1'b0;
    return w;
  endfunction : read_base

  region_decode u_decode (
    .base_bits(st_r.base[st_r.rnr]),
    .attr(st_r.attr[st_r.rnr]),
    .view(dec_view)
  );

  always_comb begin
    logic [2:0] tgt;
    logic [31:0] cur;
    logic [31:0] merged;
    tgt = 3'h0;
    cur = 32'h0000_0000;
    merged = 32'h0000_0000;
    st_nxt = st_r;
    st_nxt.rdata = 32'h0000_0000;
    st_nxt.last_wr = WR_IDLE;

    if (req.wr && is_base(req.addr)) begin
      tgt = st_r.rnr;
      // valid high selects the written region
      if (req.wdata[`BASE_VALID_BIT]) begin
        tgt = req.wdata[`BASE_REGION_LSB +: 3];
        st_nxt.rnr = tgt;
      end
      // base stored for the chosen region
      st_nxt.base[tgt] = req.wdata[31:`BASE_ADDR_LSB];
      st_nxt.last_wr = WR_BASE;
    end else if (req.wr && is_attr(req.addr)) begin
      cur = pack_attr(st_r.attr[st_r.rnr]);
      merged = cur;
      if (hw_sel[0]) begin
        merged[15:0] = req.wdata[15:0];
      end
      if (hw_sel[1]) begin
        merged[31:16] = req.wdata[31:16];
      end
      st_nxt.attr[st_r.rnr] = unpack_attr(merged);
      st_nxt.last_wr = WR_ATTR;
    end else if (req.wr && req.addr == `OFS_REGION_NUMBER) begin
      st_nxt.rnr = req.wdata[2:0];
    end

    if (req.rd) begin
      if (is_base(req.addr)) begin
        st_nxt.rdata = read_base(st_r.base[st_r.rnr], st_r.rnr,
                                 st_r.attr[st_r.rnr].size);
      end else if (is_attr(req.addr)) begin
        st_nxt.rdata = pack_attr(st_r.attr[st_r.rnr]);
      end else if (req.addr == `OFS_REGION_NUMBER) begin
        st_nxt.rdata = {29'h0000_0000, st_r.rnr};
      end else if (req.addr == `OFS_REGION_STATUS) begin
        // status shows which regions are live
        st_nxt.rdata = {{(32 - REGIONS){1'b0}}, st_r.on};
      end
    end

    // decoded view lags a write by one cycle
    st_nxt.view = dec_view;
    for (int i = 0; i < REGIONS; i++) begin
      st_nxt.on[i] = st_r.attr[i].enable &&
                     (st_r.attr[i].size >= `SIZE_MIN);
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r.rnr <= `REGION_NUMBER_RESET;
      for (int i = 0; i < REGIONS; i++) begin
        st_r.base[i] <= `BASE_RESET;
        st_r.attr[i] <= unpack_attr(`ATTR_RESET);
      end
      st_r.rdata <= 32'h0000_0000;
      st_r.view <= '0;
      st_r.on <= '0;
      st_r.last_wr <= WR_IDLE;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata = st_r.rdata;
  assign cur_view = st_r.view;
  assign cur_region = st_r.rnr;
  assign region_on = st_r.on;
endmodule : mpu_region_config_regs

/* File: core/mpu_region_consts.svh */
// offsets, field positions and reset values of the region programming block
`ifndef MPU_REGION_CONSTS_SVH
`define MPU_REGION_CONSTS_SVH

`define OFS_REGION_NUMBER 8'h00
`define OFS_REGION_BASE 8'h04
`define OFS_REGION_ATTR 8'h08
`define OFS_REGION_BASE_A1 8'h0C
`define OFS_REGION_ATTR_A1 8'h10
`define OFS_REGION_STATUS 8'h14

`define BASE_VALID_BIT 4
`define BASE_REGION_LSB 0
`define BASE_ADDR_LSB 5

`define ATTR_ENABLE_BIT 0
`define ATTR_SIZE_LSB 1
`define ATTR_SRD_LSB 8
`define ATTR_B_BIT 16
`define ATTR_C_BIT 17
`define ATTR_S_BIT 18
`define ATTR_TEX_LSB 19
`define ATTR_AP_LSB 24
`define ATTR_XN_BIT 28

`define SIZE_MIN 5'h04
`define SIZE_FULL 5'h1F
`define SIZE_NO_SUBREGION 5'h06
`define ATTR_RESET 32'h0000_0000
`define BASE_RESET 27'h000_0000
`define REGION_NUMBER_RESET 3'h0

`endif

/* File: core/mpu_region_pkg.sv */
// types of the region programming block
package mpu_region_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  typedef struct packed {
    logic xn;
    logic [2:0] ap;
    logic [2:0] type_extension;
    logic s;
    logic c;
    logic b;
    logic [7:0] subregion_disable_mask;
    logic [4:0] size;
    logic enable;
  } region_attr_t;

  typedef struct packed {
    logic [31:0] base;
    logic [31:0] limit_mask;
    logic [7:0] sub_on;
    logic xn;
    logic [2:0] ap;
    logic [2:0] type_extension;
    logic s;
    logic c;
    logic b;
    logic active;
  } region_view_t;

  typedef enum logic [1:0] {
    WR_IDLE,
    WR_BASE,
    WR_ATTR
  } wr_kind_t;
endpackage : mpu_region_pkg

/* File: core/region_decode.sv */
// effective base, address mask and subregion enables of one region
`timescale 1ns/1ps
`include "mpu_region_consts.svh"
module region_decode (
  // stored settings
  input wire logic [26:0] base_bits,
  input wire mpu_region_pkg::region_attr_t attr,
  // decoded view
  output mpu_region_pkg::region_view_t view
);
  import mpu_region_pkg::*;

  logic [31:0] mask;
  logic full;

  always_comb begin
    // size is two to the size plus one
    mask = 32'hFFFF_FFFF >> (5'h1F - attr.size);
    // top code is the whole map
    full = (attr.size == `SIZE_FULL);
    view.base = full ? 32'h0000_0000 :
                ({base_bits, 5'h00} & ~mask);
    view.limit_mask = mask;
    view.sub_on = (attr.size < `SIZE_NO_SUBREGION + 5'h01) ? 8'hFF :
                  ~attr.subregion_disable_mask;
    view.xn = attr.xn;
    view.ap = attr.ap;
    view.type_extension = attr.type_extension;
    view.s = attr.s;
    view.c = attr.c;
    view.b = attr.b;
    // sizes under the minimum never activate
    view.active = attr.enable && (attr.size >= `SIZE_MIN);
  end
endmodule : region_decode

/* File: test/mpu_region_checker.sv */
// port assertions of the region programming registers
`timescale 1ns/1ps
`include "mpu_region_consts.svh"
module mpu_region_checker #(
  parameter int REGIONS = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // register port
  input wire mpu_region_pkg::reg_req_t req,
  input wire logic [1:0] hw_sel,
  input wire logic [31:0] rdata,
  // current region
  input wire mpu_region_pkg::region_view_t cur_view,
  input wire logic [2:0] cur_region,
  input wire logic [REGIONS-1:0] region_on
);
  import mpu_region_pkg::*;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);
  logic bw, aw, br, ar;
  assign bw = req.wr && req.addr == `OFS_REGION_BASE;
  assign aw = req.wr && req.addr == `OFS_REGION_BASE_A1;
  assign br = req.rd && req.addr == `OFS_REGION_BASE;
  assign ar = req.rd && req.addr == `OFS_REGION_BASE_A1;
  AST_VALID_RD: assert property ($past(br) |-> !rdata[4])
    else $error("valid bit read back set");
  AST_REGION_RD: assert property (
    $past(br) |-> rdata[3:0] == {1'b0, cur_region})
    else $error("region field differs from held number");
  AST_ALIAS_RD: assert property (
    $past(ar) |-> rdata[4:0] == {2'b00, cur_region})
    else $error("alias read of region field wrong");
  AST_VALID_LOAD: assert property (
    bw && req.wdata[4] |=> cur_region == $past(req.wdata[2:0]))
    else $error("valid write did not load region number");
  AST_VALID_KEEP: assert property (
    bw && !req.wdata[4] |=> $stable(cur_region))
    else $error("plain base write moved region number");
  AST_ALIAS_LOAD: assert property (
    aw && req.wdata[4] |=> cur_region == $past(req.wdata[2:0]))
    else $error("alias valid write did not load region");
  AST_RNR_WR: assert property (
    req.wr && req.addr == `OFS_REGION_NUMBER
    |=> cur_region == $past(req.wdata[2:0]))
    else $error("region number write lost");
  AST_RNR_HOLD: assert property (!req.wr |=> $stable(cur_region))
    else $error("region number changed without write");
endmodule : mpu_region_checker

/* File: test/mpu_region_config_regs_bench.sv */
// self-checking bench of the region programming registers
`timescale 1ns/1ps
`include "mpu_region_consts.svh"
module mpu_region_config_regs_bench;
  import mpu_region_pkg::*;
  logic core_clk, rst_n;
  reg_req_t req;
  logic [1:0] hw_sel, h;
  logic [31:0] rdata, x, seed, bm[8], am[8];
  region_view_t cur_view;
  logic [2:0] cur_region, rn;
  logic [7:0] region_on;
  logic [4:0] szt[8] = '{5'h04, 5'h09, 5'h13, 5'h1D, 5'h1F, 5'h05,
                         5'h06, 5'h07};
  int num_errors, compares;
  mpu_region_config_regs i_mpu_region_config_regs (.core_clk(core_clk),
    .rst_n(rst_n), .req(req), .hw_sel(hw_sel), .rdata(rdata),
    .cur_view(cur_view), .cur_region(cur_region), .region_on(region_on));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  // offsets inside a region of the given size code
  function automatic logic [31:0] lim(logic [4:0] s);
    logic [63:0] m;
    m = (64'h1 << (s + 6'h01)) - 64'h1;
    return m[31:0];
  endfunction : lim
  // base as read: bits below the region size dropped, 4 GB gives zero
  function automatic logic [31:0] ebase();
    return bm[rn] & ~lim(am[rn][5:1]) & 32'hFFFFFFE0;
  endfunction : ebase
  // live regions: enabled and at least the minimum size
  function automatic logic [7:0] onx();
    logic [7:0] v;
    for (int i = 0; i < 8; i++) v[i] = am[i][0] && am[i][5:1] >= 5'h04;
    return v;
  endfunction : onx
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    compares++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic wr(logic [7:0] a, logic [31:0] v, logic [1:0] hs);
    @(posedge core_clk);
    req <= '{a, v, 1'b1, 1'b0};
    hw_sel <= hs;
    @(posedge core_clk);
    req.wr <= 1'b0;
    // outputs launched by this edge settle first
    #1;
  endtask : wr
  task automatic rd(logic [7:0] a, logic [31:0] e);
    @(posedge core_clk);
    req <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge core_clk);
    req.rd <= 1'b0;
    #1 chk("rdata", rdata, e);
  endtask : rd
  task automatic wb(logic [7:0] a, logic [31:0] v);
    wr(a, v, 2'h3);
    if (v[4]) rn = v[2:0];
    bm[rn] = v;
  endtask : wb
  // unused lanes and reserved bits are not kept
  task automatic wa(logic [7:0] a, logic [31:0] v, logic [1:0] hs);
    wr(a, v, hs);
    if (hs[0]) am[rn][15:0] = v[15:0] & 16'hFF3F;
    if (hs[1]) am[rn][31:16] = v[31:16] & 16'h173F;
  endtask : wa
  task automatic wrap_up();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  initial begin
    repeat (20000) @(posedge core_clk);
    num_errors++;
    wrap_up();
  end
  initial begin
    rst_n = 1'b0;
    req = '0;
    hw_sel = 2'h3;
    rn = 3'h0;
    seed = 32'h505A;
    num_errors = 0;
    compares = 0;
    for (int i = 0; i < 8; i++) begin
      bm[i] = 32'h0;
      am[i] = 32'h0;
    end
    repeat (20) @(posedge core_clk);
    rst_n <= 1'b1;
    rd(8'hFC, 32'h0);
    rd(`OFS_REGION_BASE, 32'h0);
    // table sizes first: minimum, examples, full map
    for (int i = 0; i < 8; i++) begin
      wb(`OFS_REGION_BASE, rnd() & 32'hFFFFFFE0 | 32'h10 | i);
      x = rnd();
      x[15:0] = {10'h000, szt[i], 1'b1};
      wa(`OFS_REGION_ATTR, x, 2'h3);
      rd(`OFS_REGION_BASE, ebase() | rn);
    end
    // undersized code on the last region must stay off
    wa(`OFS_REGION_ATTR, 32'h0000_0007, 2'h3);
    rd(`OFS_REGION_STATUS, {24'h0, onx()});
    chk("active", cur_view.active, 1'b0);
    chk("region_on", region_on, onx());
    repeat (40) begin
      x = rnd();
      wr(`OFS_REGION_NUMBER, x, 2'h3);
      rn = x[2:0];
      chk("cur_region", cur_region, rn);
      x = rnd() & 32'hFFFFFFF7;
      h = x[10:9];
      // base aligned to the size of the region it lands in
      x = x & ~lim(am[x[4] ? x[2:0] : rn][5:1]) | x[4:0];
      wb(h[0] ? `OFS_REGION_BASE_A1 : `OFS_REGION_BASE, x);
      chk("cur_region", cur_region, rn);
      rd(h[1] ? `OFS_REGION_BASE_A1 : `OFS_REGION_BASE,
         ebase() | rn);
      x = rnd();
      x[5:1] = 5'h04 + x[5:1] % 5'h1C;
      if (x[5:1] <= 5'h06) x[15:8] = 8'h00;
      h = x[30:29] == 2'h0 ? 2'h3 : x[30:29];
      wa(x[11] ? `OFS_REGION_ATTR_A1 : `OFS_REGION_ATTR, x, h);
      rd(x[12] ? `OFS_REGION_ATTR_A1 : `OFS_REGION_ATTR, am[rn]);
      rd(`OFS_REGION_BASE, ebase() | rn);
      chk("xn", cur_view.xn, am[rn][28]);
      chk("sub_on", cur_view.sub_on,
          8'(am[rn][5:1] > 5'h06 ? ~am[rn][15:8] : 8'hFF));
      chk("view_base", cur_view.base, ebase());
      chk("limit_mask", cur_view.limit_mask, lim(am[rn][5:1]));
      chk("active", cur_view.active,
          am[rn][0] && am[rn][5:1] >= 5'h04);
      chk("attr", {cur_view.ap, cur_view.type_extension, cur_view.s, cur_view.c,
          cur_view.b}, {am[rn][26:24], am[rn][21:16]});
      rd(`OFS_REGION_STATUS, {24'h0, onx()});
      chk("region_on", region_on, onx());
    end
    wrap_up();
  end
endmodule : mpu_region_config_regs_bench
bind mpu_region_config_regs mpu_region_checker #(.REGIONS(REGIONS))
  i_mpu_region_checker (.core_clk(core_clk), .rst_n(rst_n), .req(req),
  .hw_sel(hw_sel), .rdata(rdata), .cur_view(cur_view),
  .cur_region(cur_region), .region_on(region_on));
